// file: include/pdc_pkg.sv
// shared constants and types for the page descriptor check block
package pdc_pkg;
  // ------------------------------------------------------------
  // descriptor store geometry
  // ------------------------------------------------------------
  localparam int DESC_CNT = 16;
  localparam int SEL_W = 4;
  localparam int DESC_W = 16;
  localparam int BLK_W = 7;
  // ------------------------------------------------------------
  // descriptor field positions
  // ------------------------------------------------------------
  localparam int BYPASS_BIT = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 8;
  localparam int WRITTEN_BIT = 6;
  localparam int DIR_BIT = 3;
  localparam int KEY_HI = 2;
  localparam int KEY_LO = 1;
  // software may store bits 15:8, 3:1; bit 6 is hardware owned
  localparam logic [15:0] DESC_SW_MASK = 16'hFF0E;
  localparam logic [15:0] DESC_RESET = 16'h0000;
  // ------------------------------------------------------------
  // virtual address block number field
  // ------------------------------------------------------------
  localparam int VBLK_HI = 12;
  localparam int VBLK_LO = 6;
  // ------------------------------------------------------------
  // abort flag positions in the status word
  // ------------------------------------------------------------
  localparam int FLAG_NONRES = 15;
  localparam int FLAG_LEN = 14;
  localparam int FLAG_RDONLY = 13;
  localparam logic [15:0] FLAG_MASK = 16'hE000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  // ------------------------------------------------------------
  // apb map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_DESC_BASE = 8'h00;
  localparam logic [7:0] OFS_DESC_LAST = 8'h3C;
  localparam logic [7:0] OFS_FLAGS = 8'h40;
  // ------------------------------------------------------------
  // access key codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KEY_NONRES = 2'h0,
    KEY_RDONLY = 2'h1,
    KEY_UNUSED = 2'h2,
    KEY_RDWR = 2'h3
  } pdc_key_e;
endpackage

// file: hdl/pdc_desc_mem.sv
// descriptor store with written-bit maintenance and two registered read ports
`timescale 1ns/10ps
`default_nettype none
module pdc_desc_mem
  import pdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [SEL_W-1:0] wr_idx,
  input wire logic [DESC_W-1:0] wr_data,
  input wire logic clr_en,
  input wire logic [SEL_W-1:0] clr_idx,
  input wire logic set_en,
  input wire logic [SEL_W-1:0] set_idx,
  input wire logic [SEL_W-1:0] ra_idx,
  output logic [DESC_W-1:0] ra_data_ff,
  input wire logic [SEL_W-1:0] rb_idx,
  output logic [DESC_W-1:0] rb_data_ff
);
  logic [DESC_W-1:0] mem_ff [DESC_CNT];
  logic [DESC_W-1:0] nxt_mem [DESC_CNT];

  // software write stores the writable bits and clears the written bit
  always_comb begin
    for (int i = 0; i < DESC_CNT; i++) begin
      nxt_mem[i] = mem_ff[i];
      if (wr_en && wr_idx == SEL_W'(i)) begin
        nxt_mem[i] = wr_data & DESC_SW_MASK;
      end
      if (clr_en && clr_idx == SEL_W'(i)) begin
        nxt_mem[i][WRITTEN_BIT] = 1'b0;
      end
      if (set_en && set_idx == SEL_W'(i)) begin
        nxt_mem[i][WRITTEN_BIT] = 1'b1;
      end
    end
  end

  // storage and registered read ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DESC_CNT; i++) begin
        mem_ff[i] <= DESC_RESET;
      end
      ra_data_ff <= DESC_RESET;
      rb_data_ff <= DESC_RESET;
    end else begin
      for (int i = 0; i < DESC_CNT; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      ra_data_ff <= mem_ff[ra_idx];
      rb_data_ff <= mem_ff[rb_idx];
    end
  end
endmodule
`default_nettype wire

// file: hdl/pdc_check.sv
// page descriptor check: access keys, page length, bypass, written bit, apb access
// What this block does
// - bypass bit sends reference to main memory
// - bypassed cache hit invalidates the line
// - page length held in bits 14:8
// - upward page: block above length aborts
// - bit 3 chooses growth direction
// - writes set the read-only written bit
// - base or descriptor write clears written bit
// - key decode: 0,2 abort; 1 read; 3 all
// - every reference checked, vector fetch included
// - block number is address bits 12:6
// - abort sets flag 15, 14 or 13
`timescale 1ns/10ps
`default_nettype none
module pdc_check
  import pdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_valid,
  input wire logic ref_write,
  input wire logic [SEL_W-1:0] ref_sel,
  input wire logic [15:0] ref_vaddr,
  input wire logic ref_cache_hit,
  input wire logic base_write,
  input wire logic [SEL_W-1:0] base_write_sel,
  output logic res_valid_ff,
  output logic res_bypass_ff,
  output logic res_inval_ff,
  output logic res_abort_ff,
  output logic [15:0] abort_flags_ff
);
  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // key decode: true when the access must abort
  function automatic logic key_aborts(input logic [1:0] key, input logic wr);
    case (pdc_key_e'(key))
      KEY_NONRES: key_aborts = 1'b1;
      KEY_RDONLY: key_aborts = wr;
      KEY_UNUSED: key_aborts = 1'b1;
      KEY_RDWR: key_aborts = 1'b0;
      default: key_aborts = 1'b1;
    endcase
  endfunction

  // length test against the page boundary in the chosen direction
  function automatic logic len_bad(input logic [BLK_W-1:0] blk,
                                   input logic [BLK_W-1:0] len, input logic down);
    if (down) begin
      len_bad = blk < len;
    end else begin
      len_bad = blk > len;
    end
  endfunction

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic acc;
  logic desc_hit;
  logic flags_hit;
  logic [SEL_W-1:0] apb_idx;
  logic [DESC_W-1:0] apb_desc;
  logic [DESC_W-1:0] chk_desc;

  // zero wait slave; descriptors at word offsets, flags just above
  always_comb begin
    acc = psel && penable;
    desc_hit = paddr[1:0] == 2'h0 && paddr <= OFS_DESC_LAST;
    flags_hit = paddr == OFS_FLAGS;
    apb_idx = paddr[SEL_W+1:2];
    pready = 1'b1;
    pslverr = acc && !desc_hit && !flags_hit;
    prdata = 32'h0000_0000;
    if (acc && desc_hit) begin
      prdata = {16'h0000, apb_desc};
    end else if (acc && flags_hit) begin
      prdata = {16'h0000, abort_flags_ff};
    end
  end

  // ------------------------------------------------------------
  // request stage: descriptor read is registered inside the store
  // ------------------------------------------------------------
  logic s1_valid_ff, s1_write_ff, s1_hit_ff;
  logic [BLK_W-1:0] s1_blk_ff;
  logic [SEL_W-1:0] s1_sel_ff;
  logic nxt_s1_valid, nxt_s1_write, nxt_s1_hit;
  logic [BLK_W-1:0] nxt_s1_blk;
  logic [SEL_W-1:0] nxt_s1_sel;

  // capture the reference alongside the descriptor lookup
  always_comb begin
    nxt_s1_valid = ref_valid;
    nxt_s1_write = ref_valid && ref_write;
    nxt_s1_hit = ref_valid && ref_cache_hit;
    nxt_s1_blk = ref_vaddr[VBLK_HI:VBLK_LO];
    nxt_s1_sel = ref_sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid_ff <= 1'b0;
      s1_write_ff <= 1'b0;
      s1_hit_ff <= 1'b0;
      s1_blk_ff <= 7'h00;
      s1_sel_ff <= 4'h0;
    end else begin
      s1_valid_ff <= nxt_s1_valid;
      s1_write_ff <= nxt_s1_write;
      s1_hit_ff <= nxt_s1_hit;
      s1_blk_ff <= nxt_s1_blk;
      s1_sel_ff <= nxt_s1_sel;
    end
  end

  // ------------------------------------------------------------
  // check stage
  // ------------------------------------------------------------
  logic k_abort, l_abort, any_abort, set_written;
  logic [BLK_W-1:0] page_len;
  logic nxt_valid, nxt_bypass, nxt_inval, nxt_abort;
  logic [15:0] nxt_flags;

  // evaluate the selected descriptor and update the sticky flags
  always_comb begin
    page_len = chk_desc[LEN_HI:LEN_LO];
    k_abort = s1_valid_ff && key_aborts(chk_desc[KEY_HI:KEY_LO], s1_write_ff);
    l_abort = s1_valid_ff && len_bad(s1_blk_ff, page_len, chk_desc[DIR_BIT]);
    any_abort = k_abort || l_abort;
    set_written = s1_write_ff && !any_abort;
    nxt_valid = s1_valid_ff;
    nxt_abort = any_abort;
    nxt_bypass = s1_valid_ff && !any_abort && chk_desc[BYPASS_BIT];
    nxt_inval = nxt_bypass && s1_hit_ff;
    nxt_flags = abort_flags_ff;
    if (acc && pwrite && flags_hit) begin
      nxt_flags = pwdata[15:0] & FLAG_MASK;
    end
    // hardware set wins over a software clear in the same cycle
    if (k_abort && chk_desc[KEY_LO] == 1'b0) begin
      nxt_flags[FLAG_NONRES] = 1'b1;
    end
    if (l_abort) begin
      nxt_flags[FLAG_LEN] = 1'b1;
    end
    if (k_abort && chk_desc[KEY_LO] == 1'b1) begin
      nxt_flags[FLAG_RDONLY] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid_ff <= 1'b0;
      res_bypass_ff <= 1'b0;
      res_inval_ff <= 1'b0;
      res_abort_ff <= 1'b0;
      abort_flags_ff <= FLAG_RESET;
    end else begin
      res_valid_ff <= nxt_valid;
      res_bypass_ff <= nxt_bypass;
      res_inval_ff <= nxt_inval;
      res_abort_ff <= nxt_abort;
      abort_flags_ff <= nxt_flags;
    end
  end

  // ------------------------------------------------------------
  // descriptor store
  // ------------------------------------------------------------
  pdc_desc_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(acc && pwrite && desc_hit),
    .wr_idx(apb_idx),
    .wr_data(pwdata[15:0]),
    .clr_en(base_write),
    .clr_idx(base_write_sel),
    .set_en(set_written),
    .set_idx(s1_sel_ff),
    .ra_idx(apb_idx),
    .ra_data_ff(apb_desc),
    .rb_idx(ref_sel),
    .rb_data_ff(chk_desc)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_req;
    ref_valid;
  endsequence
  sequence s_result;
    ##2 res_valid_ff;
  endsequence

  chk_result_latency: assert property (s_req |-> s_result)
    else $error("result did not follow a reference by two cycles");
  chk_bypass_bit: assert property (res_bypass_ff |-> $past(chk_desc[BYPASS_BIT]))
    else $error("bypass without descriptor bypass bit");
  chk_inval_hit: assert property (
    ref_valid && ref_cache_hit ##2 res_bypass_ff |-> res_inval_ff)
    else $error("bypassed hit did not invalidate");
  chk_key_zero: assert property (
    s1_valid_ff && chk_desc[KEY_HI:KEY_LO] == 2'h0 |=> res_abort_ff && abort_flags_ff[FLAG_NONRES])
    else $error("nonresident key did not abort");
  chk_rdonly_write: assert property (
    s1_write_ff && chk_desc[KEY_HI:KEY_LO] == 2'h1 |=> abort_flags_ff[FLAG_RDONLY])
    else $error("write to read-only page not flagged");
  chk_len_up: assert property (
    s1_valid_ff && !chk_desc[DIR_BIT] && s1_blk_ff > chk_desc[LEN_HI:LEN_LO]
    |=> abort_flags_ff[FLAG_LEN])
    else $error("upward length violation missed");
  chk_len_down: assert property (
    s1_valid_ff && chk_desc[DIR_BIT] && s1_blk_ff < chk_desc[LEN_HI:LEN_LO]
    |=> res_abort_ff)
    else $error("downward length violation missed");
  chk_rdwr_ok: assert property (
    s1_valid_ff && chk_desc[KEY_HI:KEY_LO] == 2'h3 && !chk_desc[DIR_BIT]
    && s1_blk_ff <= chk_desc[LEN_HI:LEN_LO] |=> !res_abort_ff)
    else $error("permitted access aborted");
  chk_written_set: assert property (
    set_written && !(acc && pwrite && desc_hit && apb_idx == s1_sel_ff)
    ##1 ref_sel == $past(s1_sel_ff) |=> chk_desc[WRITTEN_BIT])
    else $error("written bit not set by write");
  chk_written_clr: assert property (
    base_write && !set_written ##1 !set_written && ref_sel == $past(base_write_sel)
    |=> !chk_desc[WRITTEN_BIT])
    else $error("written bit not cleared by base write");
endmodule
`default_nettype wire

// file: bench/pdc_cpu_model.sv
// cpu address path and cache model that issues relocated references
`timescale 1ns/10ps
`default_nettype none
module pdc_cpu_model
  import pdc_pkg::*;
(
  input wire logic pclk,
  output logic ref_valid,
  output logic ref_write,
  output logic [SEL_W-1:0] ref_sel,
  output logic [15:0] ref_vaddr,
  output logic ref_cache_hit,
  input wire logic res_valid_ff,
  input wire logic res_bypass_ff,
  input wire logic res_inval_ff,
  input wire logic res_abort_ff,
  input wire logic [15:0] abort_flags_ff
);
  // quiet lines from time zero
  initial begin
    ref_valid = 1'b0;
    ref_write = 1'b0;
    ref_sel = '0;
    ref_vaddr = 16'h0000;
    ref_cache_hit = 1'b0;
  end
  // one reference, then a bounded wait for its result
  task automatic do_ref(input logic w, input logic [SEL_W-1:0] s, input logic [15:0] va,
      input logic hit, output logic [31:0] res, output logic ok);
    ok = 1'b0;
    res = 32'h0;
    @(posedge pclk);
    ref_valid <= 1'b1;
    ref_write <= w;
    ref_sel <= s;
    ref_vaddr <= va;
    ref_cache_hit <= hit;
    @(posedge pclk);
    ref_valid <= 1'b0;
    ref_write <= ~w; // stale qualifiers never repeat the last value
    ref_vaddr <= ~va;
    ref_cache_hit <= ~hit;
    for (int n = 0; n < 6 && !ok; n++) begin
      @(posedge pclk);
      if (res_valid_ff === 1'b1) begin
        ok = 1'b1;
        res = {13'h0, res_abort_ff, res_bypass_ff, res_inval_ff, abort_flags_ff};
      end
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the page descriptor check block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pdc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic base_write = 1'b0;
  logic [SEL_W-1:0] base_write_sel = '0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e;
  logic rv, rw, rh, ov, ob, oi, oa;
  logic [SEL_W-1:0] rs;
  logic [15:0] va, of;
  int err_total = 0;
  int check_count = 0;
  // ----------------------------------------------------------
  // clock, device and cpu model
  // ----------------------------------------------------------
  always #20 pclk = ~pclk;
  pdc_check i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_valid(rv), .ref_write(rw), .ref_sel(rs), .ref_vaddr(va),
    .ref_cache_hit(rh), .base_write(base_write), .base_write_sel(base_write_sel),
    .res_valid_ff(ov), .res_bypass_ff(ob), .res_inval_ff(oi), .res_abort_ff(oa),
    .abort_flags_ff(of));
  pdc_cpu_model i_cpu (.pclk(pclk), .ref_valid(rv), .ref_write(rw), .ref_sel(rs),
    .ref_vaddr(va), .ref_cache_hit(rh), .res_valid_ff(ov), .res_bypass_ff(ob),
    .res_inval_ff(oi), .res_abort_ff(oa), .abort_flags_ff(of));
  // ----------------------------------------------------------
  // reporting and apb tasks
  // ----------------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !done; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        done = 1'b1;
        r = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      err_total++;
      test_done();
    end
  endtask
  // program descriptor 1, issue one reference, compare result and flags
  task automatic tref(input logic [15:0] d, input logic w, input logic [6:0] b,
      input logic hit);
    logic kf, lf, rf, ab, by, ok;
    logic [31:0] res;
    kf = (d[2:1] == 2'h0) || (d[2:1] == 2'h2);
    lf = d[3] ? (b < d[14:8]) : (b > d[14:8]);
    rf = w && (d[2:1] == 2'h1);
    ab = kf | lf | rf;
    by = d[15] & ~ab;
    apb(1'b1, OFS_FLAGS, 32'h0);
    apb(1'b1, 8'h04, {16'h0, d});
    i_cpu.do_ref(w, 4'h1, {3'h5, b, 6'h2A}, hit, res, ok);
    if (!ok) begin
      err_total++;
      test_done();
    end
    chk(res, {13'h0, ab, by, by & hit, kf, lf, rf, 13'h0});
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, OFS_DESC_LAST, 32'hFFFF);
    apb(1'b0, OFS_DESC_LAST, 32'h0);
    chk(r, 32'hFF0E);
    apb(1'b0, 8'h44, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    apb(1'b1, OFS_FLAGS, 32'hFFFF);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk(r, 32'hE000);
    for (int k = 0; k < 4; k++) begin
      tref({9'h07F, 4'h0, k[1:0], 1'b0}, 1'b0, 7'h05, 1'b0);
      tref({9'h07F, 4'h0, k[1:0], 1'b0}, 1'b1, 7'h05, 1'b0);
    end
    tref(16'h0A06, 1'b0, 7'h0A, 1'b0);
    tref(16'h0A06, 1'b0, 7'h0B, 1'b0);
    tref(16'h0A0E, 1'b0, 7'h0A, 1'b0);
    tref(16'h0A0E, 1'b0, 7'h09, 1'b0);
    tref(16'h0A00, 1'b1, 7'h7F, 1'b1);
    tref(16'hFF06, 1'b1, 7'h00, 1'b1);
    tref(16'hFF06, 1'b0, 7'h00, 1'b0);
    tref(16'hFF00, 1'b0, 7'h00, 1'b1);
    tref(16'h7F06, 1'b1, 7'h7F, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h7F46);
    @(posedge pclk);
    base_write <= 1'b1;
    base_write_sel <= 4'h1;
    @(posedge pclk);
    base_write <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h7F06);
    tref(16'h7F02, 1'b1, 7'h01, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h7F02);
    tref(16'h7F06, 1'b1, 7'h01, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h7F46);
    apb(1'b1, 8'h04, 32'h7F06);
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h7F06);
    test_done();
  end
  // watchdog against a hang
  initial begin
    #2000000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
